// ### include/pfm_pkg.sv
// ==========================================
// port fault manager constants and types
package pfm_pkg;
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 100000; // time base tick, 100 us
   localparam int TICK_CYCLES = TICK_NS / CLK_NS;
   localparam int TICK_US = TICK_NS / 1000;
   localparam int BASE_US = 6400; // limit timeout base unit, 6.4 ms
   localparam int OPEN_US = 25600; // open-circuit delay, 25.6 ms
   localparam int ARM_US = 900000; // open detector enable delay, 900 ms
   localparam logic [17:0] BASE_TICKS = 18'(BASE_US / TICK_US);
   localparam logic [17:0] OPEN_TICKS = 18'(OPEN_US / TICK_US);
   localparam logic [17:0] ARM_TICKS = 18'(ARM_US / TICK_US);
   localparam logic [4:0] TO_MIN = 5'h01; // 6.4 ms
   localparam logic [4:0] TO_MAX = 5'h14; // 128 ms
   localparam logic [6:0] RETRY_LOW = 7'd99;
   localparam logic [6:0] RETRY_HIGH = 7'd49;
   localparam logic [6:0] RETRY_OPEN = 7'd24;
   localparam logic [1:0] DUTY_LOW = 2'h0;
   localparam logic [1:0] DUTY_HIGH = 2'h1;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PORT_ON = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   // control field positions
   localparam int CTRL_OPEN_EN = 0;
   localparam int CTRL_STAT_SEL = 1;
   localparam int CTRL_RETRY_EN = 2;
   localparam int CTRL_DUTY = 3;
   localparam int CTRL_TBASE = 5;
   localparam logic [9:0] CTRL_RESET = 10'h020;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   // per-port state, one-hot
   typedef enum logic [3:0] {
      PFM_OFF = 4'h1,
      PFM_ON = 4'h2,
      PFM_OCL = 4'h4,
      PFM_OPL = 4'h8
   } pfm_state_e;
   // analog indications from the front end
   typedef struct packed {
      logic uv;
      logic [3:0] good;
      logic [3:0] limit;
      logic [3:0] lowcur;
   } pfm_sense_s;
endpackage : pfm_pkg

// ### verification/pfm_front_model.sv
`timescale 1ns/1ps
// ==========================================
// front end model, load per port: 0 normal, 1 overload, 2 open
module pfm_front_model (
   // switch drive from the block
   input wire logic [3:0] switch_on,
   // scenario controls
   input wire logic uv,
   input wire logic [7:0] load_mode,
   // indications to the block
   output pfm_pkg::pfm_sense_s sense
);
   import pfm_pkg::*;
   // indications follow the switch and the chosen load
   always_comb begin
      sense.uv = uv;
      for (int i = 0; i < 4; i++) begin
         sense.limit[i] = switch_on[i] && (load_mode[2*i +: 2] == 2'h1);
         sense.good[i] = switch_on[i] && (load_mode[2*i +: 2] != 2'h1);
         // an idle switch carries no current
         sense.lowcur[i] = !switch_on[i] || (load_mode[2*i +: 2] == 2'h2);
      end
   end
endmodule : pfm_front_model

// ### verification/pfm_port_fault_manager_test.sv
`timescale 1ns/1ps
// ==========================================
// bench for the port fault manager
module pfm_port_fault_manager_test;
   import pfm_pkg::*;
   localparam int TD = 2; // short time base tick
   localparam int TO = 64 * TD; // one limit timeout in cycles
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   pfm_sense_s sense;
   logic [3:0] sw;
   logic [3:0] relay;
   logic [3:0] stat;
   logic fault_n;
   logic irq;
   logic uv = 1'b0;
   logic [7:0] mode = 8'h00;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int n;
   logic [31:0] rd;
   int ret_n [3] = '{99, 49, 24};

   pfm_port_fault_manager #(.TICK_DIV(TD)) u_pfm_port_fault_manager (
      .CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .SENSE(sense),
      .SWITCH_ON(sw), .RELAY_ON(relay), .STAT(stat), .FAULT_N(fault_n), .IRQ(irq)
   );
   pfm_front_model u_pfm_front_model (
      .switch_on(sw), .uv(uv), .load_mode(mode), .sense(sense)
   );

   // clock
   initial begin
      forever #5 clock = ~clock;
   end
   // cut a hang short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         n_errors++;
         test_done();
      end
   end

   task test_done();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task near(input string nm, input int e, input int g);
      total_checks++;
      if (g < e - 8 || g > e + 8) begin
         n_errors++;
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
      end
   endtask : near

   // one bus transfer, address phase then data phase
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer

   task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rchk

   task cyc(input int k);
      repeat (k) @(posedge clock);
   endtask : cyc

   task wait_sw(input int p, input logic v, output int k);
      k = 0;
      while (sw[p] !== v && k < 20000) begin
         @(posedge clock);
         k++;
      end
   endtask : wait_sw

   // main sequence
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rchk("ctrl", OFS_CTRL, 32'h20);
      rchk("port_on", OFS_PORT_ON, 32'h0);
      rchk("irq_mask", OFS_IRQ_MASK, 32'h0);
      xfer(1'b1, 8'h14, 32'hFFFFFFFF);
      rchk("unmapped", 8'h14, 32'h0);
      chk("fault_n", 1'b1, fault_n);
      chk("hresp", 1'b0, hresp);
      // normal power-up, status shows switch-good
      xfer(1'b1, OFS_CTRL, 32'h22);
      xfer(1'b1, OFS_IRQ_MASK, 32'hFF);
      xfer(1'b1, OFS_PORT_ON, 32'h11);
      wait_sw(0, 1'b1, n);
      cyc(10);
      chk("stat good", 4'h1, stat);
      chk("relay", 4'h1, relay);
      // undervoltage turns off switches and relays and pulls fault low
      uv <= 1'b1;
      cyc(10);
      chk("uv sw", 4'h0, sw);
      chk("uv relay", 4'h0, relay);
      chk("uv fault", 1'b0, fault_n);
      uv <= 1'b0;
      wait_sw(0, 1'b1, n);
      near("uv restart", 6, n);
      xfer(1'b1, OFS_PORT_ON, 32'h0);
      // overcurrent latch without retry, timeout base of two units
      xfer(1'b1, OFS_CTRL, 32'h42);
      mode <= 8'h01;
      xfer(1'b1, OFS_PORT_ON, 32'h1);
      wait_sw(0, 1'b1, n);
      cyc(100);
      chk("limit on", 4'h1, sw);
      chk("limit stat", 4'h0, stat);
      wait_sw(0, 1'b0, n);
      near("limit time", 2 * TO + 5, 100 + n);
      cyc(2);
      chk("oc fault", 1'b0, fault_n);
      chk("oc irq", 1'b1, irq);
      cyc(500);
      chk("oc held", 4'h0, sw);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk("oc status", 32'h100, rd & 32'h20F00);
      xfer(1'b1, OFS_IRQ_STAT, 32'h1);
      cyc(2);
      chk("irq clr", 1'b0, irq);
      xfer(1'b1, OFS_PORT_ON, 32'h0);
      cyc(4);
      chk("oc release", 1'b1, fault_n);
      chk("no restart", 4'h0, sw);
      rchk("oc flag", OFS_STATUS, 32'h0002_0000);
      // auto-retry off time for duty selects 0, 1 and 2
      for (int c = 0; c < 3; c++) begin
         xfer(1'b1, OFS_CTRL, 32'h24 | (c << 3));
         xfer(1'b1, OFS_PORT_ON, 32'h1);
         wait_sw(0, 1'b1, n);
         wait_sw(0, 1'b0, n);
         cyc(2);
         chk("retry fault", 1'b0, fault_n);
         wait_sw(0, 1'b1, n);
         near("retry off", ret_n[c] * TO, n + 2);
         xfer(1'b1, OFS_PORT_ON, 32'h0);
         cyc(4);
      end
      // open circuit on port 1
      mode <= 8'h08;
      xfer(1'b1, OFS_IRQ_STAT, 32'hFF);
      xfer(1'b1, OFS_CTRL, 32'h21);
      xfer(1'b1, OFS_PORT_ON, 32'h2);
      wait_sw(1, 1'b1, n);
      wait_sw(1, 1'b0, n);
      near("open time", 9256 * TD + 5, n);
      cyc(2);
      chk("open stat", 4'h2, stat);
      chk("open fault", 1'b0, fault_n);
      xfer(1'b0, OFS_IRQ_STAT, 32'h0);
      chk("open irq", 32'h20, rd);
      xfer(1'b1, OFS_CTRL, 32'h20);
      cyc(2);
      chk("open off stat", 4'h0, stat);
      xfer(1'b1, OFS_PORT_ON, 32'h0);
      cyc(4);
      chk("open clr", 1'b1, fault_n);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk("open flag", 32'h0, rd & 32'hF0);
      test_done();
   end
endmodule : pfm_port_fault_manager_test

// ### verilog/pfm_port_fault_manager.sv
`timescale 1ns/1ps
module pfm_port_fault_manager #(
   parameter int TICK_DIV = pfm_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [7:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // analog front end indications
   input wire pfm_pkg::pfm_sense_s SENSE,
   // port outputs
   output logic [3:0] SWITCH_ON,
   output logic [3:0] RELAY_ON,
   output logic [3:0] STAT,
   output logic FAULT_N,
   output logic IRQ
);
   import pfm_pkg::*;

   // ==========================================
   // input synchronisers
   localparam int SW = $bits(pfm_sense_s);
   logic [SW-1:0] s1, s2, s3, filt, next_filt;
   pfm_sense_s sn;
   // change accepted once second and third stage agree
   always_comb begin
      next_filt = (s2 & s3) | (filt & (s2 | s3));
   end
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt <= '0;
      end else begin
         s1 <= SENSE;
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
      end
   end
   assign sn = filt;

   // ==========================================
   // time base
   logic [15:0] pre, next_pre;
   logic tick, next_tick;
   // one tick per time base period
   always_comb begin
      next_tick = (pre == 16'(TICK_DIV - 1));
      next_pre = next_tick ? 16'h0000 : pre + 16'h0001;
   end
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pre <= 16'h0000;
         tick <= 1'b0;
      end else begin
         pre <= next_pre;
         tick <= next_tick;
      end
   end

   // ==========================================
   // registers
   logic [9:0] ctrl, next_ctrl;
   logic [3:0] port_on, next_port_on;
   logic [3:0] relay, next_relay;
   logic [7:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
   logic [31:0] rdata, next_rdata, status_word;
   logic [7:0] wadr, next_wadr, ev;
   logic wpend, next_wpend, acc, od_en, sel, rt_en;
   logic [1:0] duty;
   logic [4:0] tbase;
   assign od_en = ctrl[CTRL_OPEN_EN];
   assign sel = ctrl[CTRL_STAT_SEL];
   assign rt_en = ctrl[CTRL_RETRY_EN];
   assign duty = ctrl[CTRL_DUTY+:2];
   assign tbase = ctrl[CTRL_TBASE+:5];
   assign acc = HSEL & HTRANS[1] & HREADY;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = rdata;

   // bus decode, write in data phase, read data captured at address phase
   always_comb begin
      next_ctrl = ctrl;
      next_port_on = port_on;
      next_relay = relay;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      next_wadr = HADDR;
      next_wpend = acc & HWRITE;
      next_rdata = rdata;
      if (wpend) begin
         unique case (wadr)
            OFS_CTRL: next_ctrl = HWDATA[9:0];
            OFS_PORT_ON: begin
               next_port_on = HWDATA[3:0];
               next_relay = HWDATA[7:4];
            end
            OFS_IRQ_STAT: next_irq_stat = irq_stat & ~HWDATA[7:0];
            OFS_IRQ_MASK: next_irq_mask = HWDATA[7:0];
            default: ;
         endcase
      end
      next_irq_stat = next_irq_stat | ev; // set wins over clear
      if (acc & ~HWRITE) begin
         unique case (HADDR)
            OFS_CTRL: next_rdata = {22'h0, ctrl};
            OFS_PORT_ON: next_rdata = {24'h0, relay, port_on};
            OFS_STATUS: next_rdata = status_word;
            OFS_IRQ_STAT: next_rdata = {24'h0, irq_stat};
            OFS_IRQ_MASK: next_rdata = {24'h0, irq_mask};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ctrl <= CTRL_RESET;
         port_on <= 4'h0;
         relay <= 4'h0;
         irq_stat <= IRQ_RESET;
         irq_mask <= IRQ_RESET;
         rdata <= 32'h0000_0000;
         wadr <= 8'h00;
         wpend <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         port_on <= next_port_on;
         relay <= next_relay;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         rdata <= next_rdata;
         wadr <= next_wadr;
         wpend <= next_wpend;
      end
   end

   // ==========================================
   // timeout and off-time
   function automatic logic [17:0] to_ticks(input logic [4:0] b);
      logic [4:0] u;
      u = (b < TO_MIN) ? TO_MIN : ((b > TO_MAX) ? TO_MAX : b);
      to_ticks = 18'(u * BASE_TICKS);
   endfunction : to_ticks
   function automatic logic [17:0] off_ticks(input logic [1:0] d, input logic [17:0] t);
      logic [6:0] n;
      n = (d == DUTY_LOW) ? RETRY_LOW : ((d == DUTY_HIGH) ? RETRY_HIGH : RETRY_OPEN);
      off_ticks = 18'(n * t);
   endfunction : off_ticks
   logic [17:0] t_lim, t_off;
   assign t_lim = to_ticks(tbase);
   assign t_off = off_ticks(duty, t_lim);

   // ==========================================
   // per-port state machines
   pfm_state_e st [4], next_st [4];
   logic [17:0] ca [4], next_ca [4], cb [4], next_cb [4];
   logic [3:0] arm, next_arm, sw_good;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         next_st[i] = st[i];
         next_ca[i] = ca[i];
         next_cb[i] = cb[i];
         next_arm[i] = arm[i];
         ev[i] = 1'b0;
         ev[i+4] = 1'b0;
         unique case (st[i])
            PFM_OFF: begin
               next_ca[i] = 18'h0;
               next_cb[i] = 18'h0;
               next_arm[i] = 1'b0;
               if (port_on[i] & ~sn.uv) next_st[i] = PFM_ON;
            end
            PFM_ON: begin
               if (sn.uv | ~port_on[i]) begin
                  next_st[i] = PFM_OFF;
               end else begin
                  // limit timer restarts when limiting stops
                  next_ca[i] = sn.limit[i] ? ca[i] + 18'(tick) : 18'h0;
                  if (~arm[i]) begin
                     next_cb[i] = (sn.good[i] & ~sn.limit[i]) ? cb[i] + 18'(tick) : 18'h0;
                     next_arm[i] = (next_cb[i] >= ARM_TICKS);
                     if (next_arm[i]) next_cb[i] = 18'h0;
                  end else begin
                     next_cb[i] = (od_en & sn.lowcur[i]) ? cb[i] + 18'(tick) : 18'h0;
                  end
                  if (sn.limit[i] & next_ca[i] >= t_lim) begin
                     next_st[i] = PFM_OCL;
                     next_ca[i] = 18'h0;
                     ev[i] = 1'b1;
                  end else if (arm[i] & next_cb[i] >= OPEN_TICKS) begin
                     next_st[i] = PFM_OPL;
                     ev[i+4] = 1'b1;
                  end
               end
            end
            PFM_OCL: begin
               if (~port_on[i]) begin
                  next_st[i] = PFM_OFF;
               end else if (rt_en & ~sn.uv) begin
                  next_ca[i] = ca[i] + 18'(tick);
                  if (next_ca[i] >= t_off) next_st[i] = PFM_OFF;
               end else begin
                  next_ca[i] = 18'h0;
               end
            end
            PFM_OPL: begin
               if (~port_on[i]) next_st[i] = PFM_OFF;
            end
            default: next_st[i] = PFM_OFF;
         endcase
         sw_good[i] = (st[i] == PFM_ON) & sn.good[i] & ~sn.limit[i];
      end
   end
   always_ff @(posedge CLOCK) begin
      for (int i = 0; i < 4; i++) begin
         if (RST) begin
            st[i] <= PFM_OFF;
            ca[i] <= 18'h0;
            cb[i] <= 18'h0;
            arm[i] <= 1'b0;
         end else begin
            st[i] <= next_st[i];
            ca[i] <= next_ca[i];
            cb[i] <= next_cb[i];
            arm[i] <= next_arm[i];
         end
      end
   end

   // ==========================================
   // outputs
   logic [3:0] latched, open_flag, oc_flag, on_now, next_stat;
   logic next_fault_n;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         oc_flag[i] = (st[i] == PFM_OCL);
         open_flag[i] = (st[i] == PFM_OPL);
         on_now[i] = (st[i] == PFM_ON);
      end
      latched = oc_flag | open_flag;
      next_fault_n = ~sn.uv & ~|latched;
      next_stat = sel ? sw_good : (od_en ? open_flag : 4'h0);
   end
   assign status_word = {14'h0, FAULT_N, sn.uv, SWITCH_ON, oc_flag, open_flag, STAT};
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         SWITCH_ON <= 4'h0;
         RELAY_ON <= 4'h0;
         STAT <= 4'h0;
         FAULT_N <= 1'b1;
         IRQ <= 1'b0;
      end else begin
         SWITCH_ON <= on_now & {4{~sn.uv}};
         RELAY_ON <= relay & {4{~sn.uv}};
         STAT <= next_stat;
         FAULT_N <= next_fault_n;
         IRQ <= |(irq_stat & irq_mask);
      end
   end

   // ==========================================
   // assertions
   sequence s_lim_expire;
      st[0] == PFM_ON && port_on[0] && !sn.uv && sn.limit[0] && ca[0] + 18'(tick) >= t_lim;
   endsequence
   property p_uv_off;
      @(posedge CLOCK) disable iff (RST) sn.uv |=> !FAULT_N && SWITCH_ON == 4'h0;
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("uv not forcing off");
   property p_good;
      @(posedge CLOCK) disable iff (RST) sw_good[0] |-> !sn.limit[0] && !open_flag[0];
   endproperty
   a_good: assert property (p_good) else $error("good while limit or open");
   property p_sel_hi;
      @(posedge CLOCK) disable iff (RST) sel |=> STAT == $past(sw_good);
   endproperty
   a_sel_hi: assert property (p_sel_hi) else $error("status not good");
   property p_sel_lo;
      @(posedge CLOCK) disable iff (RST) !sel && !od_en |=> STAT == 4'h0;
   endproperty
   a_sel_lo: assert property (p_sel_lo) else $error("status not low");
   property p_open;
      @(posedge CLOCK) disable iff (RST)
         st[0] == PFM_ON && port_on[0] && !sn.uv && arm[0] && od_en && sn.lowcur[0]
         && !(sn.limit[0] && ca[0] + 18'(tick) >= t_lim)
         && cb[0] + 18'(tick) >= OPEN_TICKS |=> st[0] == PFM_OPL;
   endproperty
   a_open: assert property (p_open) else $error("open latch missed");
   property p_clear;
      @(posedge CLOCK) disable iff (RST) latched[0] && !port_on[0] |=> st[0] == PFM_OFF;
   endproperty
   a_clear: assert property (p_clear) else $error("latch not cleared");
   property p_oc;
      @(posedge CLOCK) disable iff (RST) s_lim_expire |=> oc_flag[0] ##1 !FAULT_N;
   endproperty
   a_oc: assert property (p_oc) else $error("overcurrent latch missed");
   property p_hold;
      @(posedge CLOCK) disable iff (RST) oc_flag[0] && !rt_en && port_on[0] |=> oc_flag[0];
   endproperty
   a_hold: assert property (p_hold) else $error("latch released");
   property p_fault;
      @(posedge CLOCK) disable iff (RST) latched != 4'h0 |=> !FAULT_N;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not low");
   property p_restart;
      @(posedge CLOCK) disable iff (RST) st[0] == PFM_OFF && !on_now[0] |=> st[0] != PFM_ON
         || $past(port_on[0]) && !$past(sn.uv);
   endproperty
   a_restart: assert property (p_restart) else $error("bad restart");
endmodule : pfm_port_fault_manager
